// ### hw/nva_pkg.sv
// Constants for the data byte nonvolatile store and its access control.
// Assumes an 8-bit I/O register space with 6-bit addresses.
package nva_pkg;
   // I/O register offsets
   localparam logic [5:0] OFS_CTRL = 6'h1f;
   localparam logic [5:0] OFS_DATA = 6'h20;
   localparam logic [5:0] OFS_ADRL = 6'h21;
   localparam logic [5:0] OFS_ADRH = 6'h22;
   // Control register fields
   localparam int BIT_READ = 0;
   localparam int BIT_PROG = 1;
   localparam int BIT_ARM = 2;
   localparam int BIT_RIE = 3;
   localparam int MODE_LSB = 4;
   localparam int ADRH_BITS = 4;
   // Mode field encodings
   localparam logic [1:0] MODE_ATOMIC = 2'h0;
   localparam logic [1:0] MODE_ERASE = 2'h1;
   localparam logic [1:0] MODE_WRITE = 2'h2;
   localparam logic [1:0] MODE_RSVD = 2'h3;
   localparam logic [1:0] MODE_RESET = 2'h0;
   // Array shape and erased value
   localparam int ADDR_W = 12;
   localparam int DEPTH = 4096;
   localparam logic [7:0] ERASED = 8'hff;
   localparam logic [7:0] DATA_RESET = 8'h00;
   // CPU clock cycle counts
   localparam logic [2:0] READ_STALL = 3'h4;
   localparam logic [2:0] PROG_STALL = 3'h2;
   localparam logic [2:0] ARM_WINDOW = 3'h4;
   // Programming times, timed by the calibrated oscillator
   localparam int OSC_MHZ = 1;
   localparam int WRITE_TIME_US = 4500;
   localparam int ERASE_TIME_US = 8500;
   localparam logic [15:0] WRITE_TICKS = 16'(WRITE_TIME_US * OSC_MHZ);
   localparam logic [15:0] ERASE_TICKS = 16'(ERASE_TIME_US * OSC_MHZ);
endpackage : nva_pkg

// ### hw/nva_link.sv
// Link between the access control and the programming engine.
// Assumes both ends share clk.
`timescale 1ns/1ps
interface nva_link;
   logic start;
   logic [1:0] mode;
   logic [nva_pkg::ADDR_W-1:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic busy;
   logic tick;
   modport ctrl (output start, mode, addr, wdata, tick,
                 input rdata, busy);
   modport eng (input start, mode, addr, wdata, tick,
                output rdata, busy);
endinterface : nva_link

// ### hw/nva_engine.sv
// Byte array with self-timed erase and write engine.
// Assumes tick is a one-cycle pulse per calibrated oscillator period.
`timescale 1ns/1ps
module nva_engine #(
   parameter logic [15:0] WRITE_TICKS = nva_pkg::WRITE_TICKS,
   parameter logic [15:0] ERASE_TICKS = nva_pkg::ERASE_TICKS
) (
   input wire logic clk, // CPU clock
   input wire logic por, // Power-on reset, active high
   nva_link.eng lk // Link to access control
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ERASE = 3'b010,
      ST_WRITE = 3'b100
   } nva_state_t;

   nva_state_t st_q, st_d;
   logic [15:0] cnt_q, cnt_d;
   logic [nva_pkg::ADDR_W-1:0] adr_q, adr_d;
   logic [7:0] dat_q, dat_d;
   logic atomic_q, atomic_d;
   logic mem_we;
   logic [7:0] mem_val;
   logic [7:0] mem [nva_pkg::DEPTH];

   assign lk.busy = (st_q != ST_IDLE);
   assign lk.rdata = mem[lk.addr];

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      adr_d = adr_q;
      dat_d = dat_q;
      atomic_d = atomic_q;
      mem_we = 1'b0;
      mem_val = mem[adr_q];
      case (st_q)
         ST_IDLE: begin
            if (lk.start) begin
               adr_d = lk.addr;
               dat_d = lk.wdata;
               atomic_d = (lk.mode == nva_pkg::MODE_ATOMIC);
               if (lk.mode == nva_pkg::MODE_WRITE) begin
                  st_d = ST_WRITE;
                  cnt_d = WRITE_TICKS - 16'h0001;
               end else if (lk.mode != nva_pkg::MODE_RSVD) begin
                  st_d = ST_ERASE;
                  cnt_d = ERASE_TICKS - 16'h0001;
               end
            end
         end
         ST_ERASE: begin
            if (lk.tick) begin
               if (cnt_q == 16'h0000) begin
                  mem_we = 1'b1;
                  mem_val = nva_pkg::ERASED;
                  if (atomic_q) begin
                     st_d = ST_WRITE;
                     cnt_d = WRITE_TICKS - 16'h0001;
                  end else begin
                     st_d = ST_IDLE;
                  end
               end else begin
                  cnt_d = cnt_q - 16'h0001;
               end
            end
         end
         ST_WRITE: begin
            if (lk.tick) begin
               if (cnt_q == 16'h0000) begin
                  mem_we = 1'b1;
                  mem_val = mem[adr_q] & dat_q;
                  st_d = ST_IDLE;
               end else begin
                  cnt_d = cnt_q - 16'h0001;
               end
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end

   // Only power-on reset: a system reset lets programming finish
   always_ff @(posedge clk or posedge por) begin
      if (por) begin
         st_q <= ST_IDLE;
         cnt_q <= 16'h0000;
         adr_q <= '0;
         dat_q <= 8'h00;
         atomic_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         adr_q <= adr_d;
         dat_q <= dat_d;
         atomic_q <= atomic_d;
      end
   end

   always_ff @(posedge clk) begin
      if (mem_we) begin
         mem[adr_q] <= mem_val;
      end
   end

   // Helper: oscillator ticks seen in the current phase
   logic [15:0] seen_q;
   always_ff @(posedge clk or posedge por) begin
      if (por) begin
         seen_q <= 16'h0000;
      end else if (st_q != st_d || st_q == ST_IDLE) begin
         seen_q <= 16'h0000;
      end else if (lk.tick) begin
         seen_q <= seen_q + 16'h0001;
      end
   end

   write_time_a: assert property (@(posedge clk) disable iff (por)
      (st_q == ST_WRITE && st_d != ST_WRITE)
         |-> seen_q == WRITE_TICKS - 16'h0001)
      else $error("write phase length wrong");
   erase_time_a: assert property (@(posedge clk) disable iff (por)
      (st_q == ST_ERASE && st_d != ST_ERASE)
         |-> seen_q == ERASE_TICKS - 16'h0001)
      else $error("erase phase length wrong");
   osc_count_a: assert property (@(posedge clk) disable iff (por)
      (st_q != ST_IDLE && !lk.tick) |=> $stable(cnt_q))
      else $error("counter moved without oscillator tick");
   erased_byte_a: assert property (@(posedge clk) disable iff (por)
      (st_q == ST_ERASE && st_d == ST_IDLE)
         |=> mem[adr_q] == nva_pkg::ERASED)
      else $error("erased byte not all ones");
endmodule : nva_engine

// ### hw/nva_ctrl.sv
// I/O register front end for the 4K byte nonvolatile data store.
// Assumes single-cycle I/O writes and reads on clk from the CPU core,
// and a calibrated oscillator square wave arriving on osc_pin.
`timescale 1ns/1ps
module nva_ctrl #(
   parameter logic [15:0] WRITE_TICKS = nva_pkg::WRITE_TICKS,
   parameter logic [15:0] ERASE_TICKS = nva_pkg::ERASE_TICKS
) (
   input wire logic clk, // CPU clock, 100 MHz
   input wire logic rst, // System reset, async, active high
   input wire logic por, // Power-on reset, async, active high
   input wire logic [5:0] io_addr, // I/O register address
   input wire logic io_we, // I/O write strobe
   input wire logic io_re, // I/O read strobe
   input wire logic [7:0] io_wdata, // I/O write data
   output logic [7:0] io_rdata, // I/O read data, one cycle later
   output logic cpu_stall, // Halts the CPU core
   output logic ready_irq, // Ready interrupt request level
   input wire logic osc_pin // Calibrated oscillator
);
   nva_link lk ();

   logic [7:0] adrl_q, adrl_d;
   logic [nva_pkg::ADRH_BITS-1:0] adrh_q, adrh_d;
   logic [7:0] data_q, data_d;
   logic rie_q, rie_d;
   logic [1:0] mode_q, mode_d;
   logic [2:0] arm_q, arm_d;
   logic [2:0] stall_q, stall_d;
   logic stall_out_d;
   logic irq_d;
   logic [7:0] rdata_d;
   logic wr_ctrl, rd_strobe, prog_strobe;
   logic osc_s1_q, osc_s2_q, osc_s3_q;

   function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
      hit = (a == o);
   endfunction : hit

   // Calibrated oscillator into the CPU clock domain
   always_ff @(posedge clk or posedge por) begin
      if (por) begin
         osc_s1_q <= 1'b0;
         osc_s2_q <= 1'b0;
         osc_s3_q <= 1'b0;
      end else begin
         osc_s1_q <= osc_pin;
         osc_s2_q <= osc_s1_q;
         osc_s3_q <= osc_s2_q;
      end
   end
   assign lk.tick = osc_s2_q & ~osc_s3_q;

   assign wr_ctrl = io_we & hit(io_addr, nva_pkg::OFS_CTRL);
   assign rd_strobe = wr_ctrl & io_wdata[nva_pkg::BIT_READ] & ~lk.busy;
   // Program only inside the arm window and while idle
   assign prog_strobe = wr_ctrl & io_wdata[nva_pkg::BIT_PROG]
      & (arm_q != 3'h0) & ~lk.busy;

   assign lk.start = prog_strobe;
   assign lk.mode = mode_d;
   assign lk.addr = {adrh_q, adrl_q};
   assign lk.wdata = data_q;

   always_comb begin
      adrl_d = adrl_q;
      adrh_d = adrh_q;
      data_d = data_q;
      rie_d = rie_q;
      mode_d = mode_q;
      arm_d = (arm_q != 3'h0) ? arm_q - 3'h1 : 3'h0;
      stall_d = (stall_q != 3'h0) ? stall_q - 3'h1 : 3'h0;
      // Address frozen while programming
      if (io_we && !lk.busy) begin
         if (hit(io_addr, nva_pkg::OFS_ADRL)) begin
            adrl_d = io_wdata;
         end else if (hit(io_addr, nva_pkg::OFS_ADRH)) begin
            adrh_d = io_wdata[nva_pkg::ADRH_BITS-1:0];
         end
      end
      if (io_we && hit(io_addr, nva_pkg::OFS_DATA)) begin
         data_d = io_wdata;
      end
      if (wr_ctrl) begin
         rie_d = io_wdata[nva_pkg::BIT_RIE];
         if (!lk.busy) begin
            mode_d = io_wdata[nva_pkg::MODE_LSB +: 2];
         end
         if (io_wdata[nva_pkg::BIT_ARM]) begin
            arm_d = nva_pkg::ARM_WINDOW;
         end
      end
      if (rst && !lk.busy) begin
         mode_d = nva_pkg::MODE_RESET;
      end
      if (rd_strobe) begin
         data_d = lk.rdata;
         stall_d = nva_pkg::READ_STALL;
      end else if (prog_strobe) begin
         stall_d = nva_pkg::PROG_STALL;
      end
      stall_out_d = (stall_d != 3'h0);
      irq_d = rie_d & ~lk.busy;
      rdata_d = io_rdata;
      if (io_re) begin
         if (hit(io_addr, nva_pkg::OFS_CTRL)) begin
            rdata_d = {2'h0, mode_q, rie_q, (arm_q != 3'h0),
                       lk.busy, 1'b0};
         end else if (hit(io_addr, nva_pkg::OFS_DATA)) begin
            rdata_d = data_q;
         end else if (hit(io_addr, nva_pkg::OFS_ADRL)) begin
            rdata_d = adrl_q;
         end else if (hit(io_addr, nva_pkg::OFS_ADRH)) begin
            rdata_d = {4'h0, adrh_q};
         end else begin
            rdata_d = 8'h00;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         data_q <= nva_pkg::DATA_RESET;
         rie_q <= 1'b0;
         arm_q <= 3'h0;
         stall_q <= 3'h0;
         cpu_stall <= 1'b0;
         ready_irq <= 1'b0;
         io_rdata <= 8'h00;
      end else begin
         data_q <= data_d;
         rie_q <= rie_d;
         arm_q <= arm_d;
         stall_q <= stall_d;
         cpu_stall <= stall_out_d;
         ready_irq <= irq_d;
         io_rdata <= rdata_d;
      end
   end

   // Mode survives a system reset taken during programming
   always_ff @(posedge clk or posedge por) begin
      if (por) begin
         mode_q <= nva_pkg::MODE_RESET;
      end else begin
         mode_q <= mode_d;
      end
   end

   // Address has no reset value
   always_ff @(posedge clk) begin
      adrl_q <= adrl_d;
      adrh_q <= adrh_d;
   end

   nva_engine #(
      .WRITE_TICKS(WRITE_TICKS),
      .ERASE_TICKS(ERASE_TICKS)
   ) u_engine (
      .clk(clk),
      .por(por),
      .lk(lk)
   );

   sequence stall_run4;
      cpu_stall [*4] ##1 !cpu_stall;
   endsequence
   sequence stall_run2;
      cpu_stall [*2] ##1 !cpu_stall;
   endsequence

   read_stall_a: assert property (@(posedge clk) disable iff (rst)
      rd_strobe |=> stall_run4)
      else $error("read stall not four cycles");
   prog_stall_a: assert property (@(posedge clk) disable iff (rst)
      prog_strobe |=> stall_run2)
      else $error("program stall not two cycles");
   arm_window_a: assert property (@(posedge clk) disable iff (rst)
      (wr_ctrl && io_wdata[nva_pkg::BIT_ARM])
         |=> (arm_q == nva_pkg::ARM_WINDOW))
      else $error("arm window not loaded");
   arm_close_a: assert property (@(posedge clk) disable iff (rst)
      (arm_q == 3'h1 && !(wr_ctrl && io_wdata[nva_pkg::BIT_ARM]))
         |=> (arm_q == 3'h0))
      else $error("arm window not closed");
   no_arm_start_a: assert property (@(posedge clk) disable iff (rst)
      (arm_q == 3'h0) |-> !lk.start)
      else $error("start without arm");
   prog_busy_a: assert property (@(posedge clk) disable iff (rst | por)
      (lk.start && lk.mode != nva_pkg::MODE_RSVD) |=> lk.busy)
      else $error("program flag not set after start");
   mode_hold_a: assert property (@(posedge clk) disable iff (rst | por)
      (lk.busy && $past(lk.busy)) |-> $stable(mode_q))
      else $error("mode changed while programming");
   read_data_a: assert property (@(posedge clk) disable iff (rst)
      rd_strobe |=> data_q == $past(lk.rdata))
      else $error("read strobe did not load data");
   ready_irq_a: assert property (@(posedge clk) disable iff (rst | por)
      ##1 (ready_irq == ($past(rie_d) && !$past(lk.busy))))
      else $error("ready interrupt level wrong");
   adrh_zero_a: assert property (@(posedge clk) disable iff (rst)
      $past(io_re && hit(io_addr, nva_pkg::OFS_ADRH))
         |-> io_rdata[7:4] == 4'h0)
      else $error("reserved address bits not zero");
   data_hold_a: assert property (@(posedge clk) disable iff (rst)
      $past(!rd_strobe && !(io_we && hit(io_addr, nva_pkg::OFS_DATA)))
         |-> $stable(data_q))
      else $error("data register changed unprompted");
endmodule : nva_ctrl

// ### verif/nva_cpu_model.sv
// CPU core model issuing I/O register accesses to the nonvolatile store.
// Assumes cpu_stall is registered and rises one cycle after a strobe.
`timescale 1ns/1ps
module nva_cpu_model (
   input wire logic clk, // CPU clock
   input wire logic cpu_stall, // Halt request from the store
   input wire logic [7:0] io_rdata, // Registered read data
   output logic [5:0] io_addr, // Register address
   output logic io_we, // Write strobe
   output logic io_re, // Read strobe
   output logic [7:0] io_wdata // Write data
);
   initial begin
      io_addr = 6'h00;
      io_we = 1'b0;
      io_re = 1'b0;
      io_wdata = 8'h00;
   end
   // No flash self-programming, no interrupts between steps
   // One instruction, then sit out any stall it caused
   task automatic acc(input logic we, input logic re, input logic [5:0] a,
         input logic [7:0] d);
      io_we <= we;
      io_re <= re;
      io_addr <= a;
      io_wdata <= d;
      @(posedge clk);
      io_we <= 1'b0;
      io_re <= 1'b0;
      io_wdata <= ~d;
      repeat (2) @(posedge clk);
      while (cpu_stall !== 1'b0) @(posedge clk);
   endtask : acc
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      acc(1'b1, 1'b0, a, d);
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [7:0] q);
      acc(1'b0, 1'b1, a, 8'h00);
      q = io_rdata;
   endtask : rd
   // Address loaded before any access
   task automatic addr(input logic [11:0] a);
      wr(nva_pkg::OFS_ADRH, {4'h0, a[11:8]});
      wr(nva_pkg::OFS_ADRL, a[7:0]);
   endtask : addr
   // Arm first, program bit in the next write
   task automatic prog(input logic [7:0] m);
      wr(nva_pkg::OFS_CTRL, m | 8'h04);
      wr(nva_pkg::OFS_CTRL, m | 8'h06);
   endtask : prog
   // Wait for the program flag to clear, bounded
   task automatic poll(output logic [7:0] q);
      int n;
      n = 0;
      q = 8'h02;
      while (q[1] !== 1'b0 && n < 100) begin
         rd(nva_pkg::OFS_CTRL, q);
         n++;
      end
   endtask : poll
endmodule : nva_cpu_model

// ### verif/nva_ctrl_bench.sv
// Self-checking bench for the nonvolatile store access control.
// Assumes a fast oscillator (8 clk per period) and shortened tick counts.
`timescale 1ns/1ps
module nva_ctrl_bench;
   localparam logic [15:0] WT = 16'h0003;
   localparam logic [15:0] ET = 16'h0005;
   localparam int OP = 8;
   localparam logic [5:0] CT = nva_pkg::OFS_CTRL;
   localparam logic [5:0] DT = nva_pkg::OFS_DATA;
   logic clk, rst, por, osc_pin;
   logic [5:0] io_addr;
   logic io_we, io_re, cpu_stall, ready_irq;
   logic [7:0] io_wdata, io_rdata, q;
   int fails, comparisons, st_len, st_run, ir_len, ir_run;
   nva_ctrl #(.WRITE_TICKS(WT), .ERASE_TICKS(ET)) uut (.clk(clk),
      .rst(rst), .por(por), .io_addr(io_addr), .io_we(io_we),
      .io_re(io_re), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .cpu_stall(cpu_stall), .ready_irq(ready_irq), .osc_pin(osc_pin));
   nva_cpu_model cpu (.clk(clk), .cpu_stall(cpu_stall),
      .io_rdata(io_rdata), .io_addr(io_addr), .io_we(io_we),
      .io_re(io_re), .io_wdata(io_wdata));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      osc_pin = 1'b0;
      forever #40 osc_pin = ~osc_pin;
   end
   // Lengths of the last stall and of the last ready-low stretch
   always @(negedge clk) begin
      if (cpu_stall === 1'b1) st_run++;
      else if (st_run != 0) begin
         st_len = st_run;
         st_run = 0;
      end
      if (ready_irq === 1'b0) ir_run++;
      else if (ir_run != 0) begin
         ir_len = ir_run;
         ir_run = 0;
      end
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %0t value %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic chk_rng(input int v, input int ticks);
      comparisons++;
      if (v < (ticks - 1) * OP || v > ticks * OP + 6) begin
         fails++;
         $display("[FAIL] %0t duration %0d for %0d ticks", $time, v, ticks);
      end
   endtask : chk_rng
   task automatic rd_byte(output logic [7:0] b);
      cpu.wr(CT, 8'h01);
      cpu.rd(DT, b);
   endtask : rd_byte
   task automatic t_regs;
      cpu.rd(CT, q);
      chk(q, 8'h00);
      cpu.rd(DT, q);
      chk(q, nva_pkg::DATA_RESET);
      cpu.wr(nva_pkg::OFS_ADRH, 8'hff);
      cpu.rd(nva_pkg::OFS_ADRH, q);
      chk(q, 8'h0f);
      cpu.wr(nva_pkg::OFS_ADRL, 8'hc3);
      cpu.rd(nva_pkg::OFS_ADRL, q);
      chk(q, 8'hc3);
      cpu.rd(6'h05, q);
      chk(q, 8'h00);
      cpu.wr(DT, 8'h77);
      cpu.rd(DT, q);
      chk(q, 8'h77);
      $display("test regs done");
   endtask : t_regs
   task automatic t_erase;
      cpu.addr(12'ha5c);
      cpu.prog(8'h18);
      chk(8'(st_len), 8'h02);
      cpu.rd(CT, q);
      chk(q, 8'h1e);
      cpu.wr(CT, 8'h08);
      cpu.wr(nva_pkg::OFS_ADRL, 8'h00);
      cpu.rd(CT, q);
      chk(q, 8'h1a);
      cpu.poll(q);
      chk(q, 8'h18);
      chk_rng(ir_len, int'(ET));
      chk({7'h00, ready_irq}, 8'h01);
      rd_byte(q);
      chk(8'(st_len), 8'h04);
      chk(q, nva_pkg::ERASED);
      $display("test erase done");
   endtask : t_erase
   task automatic t_write;
      cpu.wr(DT, 8'h5a);
      cpu.prog(8'h28);
      cpu.poll(q);
      chk(q, 8'h28);
      chk_rng(ir_len, int'(WT));
      rd_byte(q);
      chk(q, 8'h5a);
      $display("test write done");
   endtask : t_write
   task automatic t_atomic;
      cpu.addr(12'ha5d);
      cpu.wr(DT, 8'h33);
      cpu.prog(8'h08);
      cpu.poll(q);
      chk(q, 8'h08);
      chk_rng(ir_len, int'(ET + WT));
      rd_byte(q);
      chk(q, 8'h33);
      cpu.addr(12'ha5c);
      rd_byte(q);
      chk(q, 8'h5a);
      $display("test atomic done");
   endtask : t_atomic
   task automatic t_refuse;
      cpu.wr(CT, 8'h24);
      repeat (6) @(posedge clk);
      cpu.wr(CT, 8'h26);
      cpu.rd(CT, q);
      chk(q, 8'h24);
      cpu.prog(8'h38);
      cpu.rd(CT, q);
      chk(q, 8'h3c);
      rd_byte(q);
      chk(q, 8'h5a);
      $display("test refuse done");
   endtask : t_refuse
   task automatic t_reset;
      cpu.addr(12'ha5d);
      cpu.prog(8'h10);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      cpu.rd(CT, q);
      chk(q, 8'h12);
      cpu.poll(q);
      chk(q, 8'h10);
      rd_byte(q);
      chk(q, nva_pkg::ERASED);
      $display("test reset done");
   endtask : t_reset
   task automatic t_por;
      cpu.wr(CT, 8'h20);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      cpu.rd(CT, q);
      chk(q, 8'h00);
      cpu.wr(DT, 8'h44);
      rst <= 1'b1;
      por <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      por <= 1'b0;
      @(posedge clk);
      cpu.rd(DT, q);
      chk(q, nva_pkg::DATA_RESET);
      cpu.rd(CT, q);
      chk(q, 8'h00);
      $display("test por done");
   endtask : t_por
   task automatic test_done;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done
   initial begin
      #150us;
      fails++;
      $display("[FAIL] %0t watchdog expired", $time);
      test_done();
   end
   initial begin
      rst = 1'b1;
      por = 1'b1;
      fails = 0;
      comparisons = 0;
      st_len = 0;
      st_run = 0;
      ir_len = 0;
      ir_run = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      por <= 1'b0;
      @(posedge clk);
      t_regs();
      t_erase();
      t_write();
      t_atomic();
      t_refuse();
      t_reset();
      t_por();
      test_done();
   end
endmodule : nva_ctrl_bench
